// >>> logic/sltr_pkg.sv
`default_nettype none
package sltr_pkg;
  // register byte addresses (offsets are multiples of four: index * 4)
  localparam logic [11:0] IDX_TEST = 12'h205;
  localparam logic [11:0] IDX_IDENT = 12'h206;
  localparam logic [11:0] IDX_COMMA = 12'h207;
  localparam logic [11:0] IDX_STATUS = 12'h208;
  localparam logic [11:0] IDX_CTRL = 12'h20f;
  localparam logic [13:0] ADDR_TEST = {IDX_TEST, 2'b00};
  localparam logic [13:0] ADDR_IDENT = {IDX_IDENT, 2'b00};
  localparam logic [13:0] ADDR_COMMA = {IDX_COMMA, 2'b00};
  localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [13:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  // reset values
  localparam logic [4:0] TEST_RST = 5'h00;
  localparam logic [7:0] IDENT_RST = 8'h00;
  localparam logic [1:0] COMMA_RST = 2'h0;
  // status bit positions
  localparam int ST_LINK_UP = 6;
  localparam int ST_SYNC = 5;
  localparam int ST_REALIGNED = 4;
  localparam int ST_MULTIFRAME_PHASE_SET_FLAG = 3;
  localparam int ST_PLL = 2;
  // test select codes
  localparam logic [4:0] TP_NORMAL = 5'h00;
  localparam logic [4:0] TP_PRBS7 = 5'h01;
  localparam logic [4:0] TP_PRBS15 = 5'h02;
  localparam logic [4:0] TP_PRBS23 = 5'h03;
  localparam logic [4:0] TP_RAMP = 5'h04;
  localparam logic [4:0] TP_TRANSPORT = 5'h05;
  localparam logic [4:0] TP_D21_5 = 5'h06;
  localparam logic [4:0] TP_K28_5 = 5'h07;
  localparam logic [4:0] TP_ILA = 5'h08;
  localparam logic [4:0] TP_RPAT = 5'h09;
  localparam logic [4:0] TP_LOW = 5'h0a;
  localparam logic [4:0] TP_HIGH = 5'h0b;
  localparam logic [4:0] TP_PRBS9 = 5'h0d;
  localparam logic [4:0] TP_PRBS31 = 5'h0e;
  localparam logic [4:0] TP_CLOCK = 5'h0f;
  localparam logic [4:0] TP_K28_7 = 5'h10;
  localparam logic [15:0] CLOCK_WORD = 16'h00ff;
  // 8-bit k-character and D21.5 payloads
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [7:0] K28_1 = 8'h3c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] D21_5 = 8'hb5;
  // generator kinds
  typedef enum logic [2:0] {
    SLTR_GEN_DATA = 3'h0,
    SLTR_GEN_PRBS = 3'h1,
    SLTR_GEN_CONST = 3'h2,
    SLTR_GEN_RAMP = 3'h3,
    SLTR_GEN_ILA = 3'h4
  } sltr_gen_t;
endpackage : sltr_pkg
`default_nettype wire

// >>> logic/sltr_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sltr_pattern_gen (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // control
  input wire logic i_enable,
  input wire logic [4:0] i_select,
  input wire logic i_is_8b10b,
  input wire logic [15:0] i_data,
  // output
  output logic [15:0] o_word,
  output logic o_is_k
);
  ////////////////////////////////////////////////////////////////
  logic [30:0] lfsr_reg;
  logic [30:0] lfsr_next;
  logic [15:0] ramp_reg;
  logic [15:0] ramp_next;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic k_reg;
  logic k_next;

  // one prbs step; tap pair depends on the polynomial order
  function automatic logic [30:0] prbs_step(input logic [30:0] s, input logic [4:0] sel);
    logic fb;
    fb = 1'b0;
    unique case (sel)
      sltr_pkg::TP_PRBS7: fb = s[6] ^ s[5];
      sltr_pkg::TP_PRBS9: fb = s[8] ^ s[4];
      sltr_pkg::TP_PRBS15: fb = s[14] ^ s[13];
      sltr_pkg::TP_PRBS23: fb = s[22] ^ s[17];
      default: fb = s[30] ^ s[27];
    endcase
    return {s[29:0], fb};
  endfunction : prbs_step

  always_comb
  begin
    lfsr_next = lfsr_reg;
    ramp_next = ramp_reg;
    word_next = i_data;
    k_next = 1'b0;
    if (i_enable)
    begin
      unique case (i_select)
        sltr_pkg::TP_PRBS7, sltr_pkg::TP_PRBS15, sltr_pkg::TP_PRBS23,
        sltr_pkg::TP_PRBS9, sltr_pkg::TP_PRBS31:
        begin
          lfsr_next = prbs_step(lfsr_reg, i_select);
          word_next = lfsr_reg[15:0];
        end
        sltr_pkg::TP_RAMP:
        begin
          ramp_next = ramp_reg + 16'h0001;
          word_next = ramp_reg;
        end
        // transport pattern approximated by a fixed sample signature
        sltr_pkg::TP_TRANSPORT: word_next = {ramp_reg[7:0], 8'h5a};
        sltr_pkg::TP_D21_5: word_next = {sltr_pkg::D21_5, sltr_pkg::D21_5};
        sltr_pkg::TP_LOW: word_next = 16'h0000;
        sltr_pkg::TP_HIGH: word_next = 16'hffff;
        sltr_pkg::TP_CLOCK: word_next = sltr_pkg::CLOCK_WORD;
        sltr_pkg::TP_K28_5, sltr_pkg::TP_K28_7, sltr_pkg::TP_ILA, sltr_pkg::TP_RPAT:
        begin
          // k-character modes fall back to data outside 8b/10b
          if (i_is_8b10b)
          begin
            k_next = (i_select != sltr_pkg::TP_RPAT);
            unique case (i_select)
              sltr_pkg::TP_K28_5: word_next = {sltr_pkg::K28_5, sltr_pkg::K28_5};
              sltr_pkg::TP_K28_7: word_next = {sltr_pkg::K28_7, sltr_pkg::K28_7};
              sltr_pkg::TP_ILA: word_next = {sltr_pkg::K28_1, sltr_pkg::K28_5};
              default:
              begin
                ramp_next = ramp_reg + 16'h0101;
                word_next = ramp_reg;
              end
            endcase
          end
        end
        default: word_next = i_data;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      lfsr_reg <= 31'h7fffffff;
      ramp_reg <= 16'h0000;
      word_reg <= 16'h0000;
      k_reg <= 1'b0;
    end
    else
    begin
      lfsr_reg <= lfsr_next;
      ramp_reg <= ramp_next;
      word_reg <= word_next;
      k_reg <= k_next;
    end
  end

  assign o_word = word_reg;
  assign o_is_k = k_reg;
endmodule : sltr_pattern_gen
`default_nettype wire

// >>> logic/sltr_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sltr_regs (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [13:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // link side status
  input wire logic i_link_up,
  input wire logic i_sync_req_n,
  input wire logic i_sysref_event,
  input wire logic i_phase_shifted,
  input wire logic i_pll_locked,
  input wire logic i_is_8b10b,
  input wire logic i_eof_slot,
  input wire logic i_ila_did_slot,
  input wire logic [15:0] i_sample_data,
  // link side outputs
  output logic o_serial_link_enable,
  output logic [15:0] o_link_a_word,
  output logic o_link_a_is_k,
  output logic [15:0] o_link_b_word,
  output logic o_link_b_is_k
);
  ////////////////////////////////////////////////////////////////
  logic [4:0] test_reg;
  logic [4:0] test_next;
  logic [7:0] did_reg;
  logic [7:0] did_next;
  logic [1:0] comma_sel_reg;
  logic [1:0] comma_sel_next;
  logic en_reg;
  logic en_next;
  logic realigned_reg;
  logic realigned_next;
  logic multiframe_phase_set_flag_reg;
  logic multiframe_phase_set_flag_next;
  logic armed_reg;
  logic armed_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_next;
  logic [15:0] a_reg;
  logic [15:0] a_next;
  logic [15:0] b_reg;
  logic [15:0] b_next;
  logic ak_reg;
  logic ak_next;
  logic bk_reg;
  logic bk_next;
  logic [15:0] gen_word;
  logic gen_k;
  logic acc;
  logic wr;
  logic [7:0] status;

  // comma character for the end-of-frame select
  function automatic logic [7:0] eof_char(input logic [1:0] sel);
    unique case (sel)
      2'h1: return sltr_pkg::K28_1;
      2'h2: return sltr_pkg::K28_5;
      default: return sltr_pkg::K28_7;
    endcase
  endfunction : eof_char

  ////////////////////////////////////////////////////////////////
  // zero-wait apb: answer in the access cycle
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign o_pready = 1'b1;

  always_comb
  begin
    status = 8'h00;
    status[sltr_pkg::ST_LINK_UP] = i_link_up;
    status[sltr_pkg::ST_SYNC] = i_sync_req_n;
    status[sltr_pkg::ST_REALIGNED] = realigned_reg;
    status[sltr_pkg::ST_MULTIFRAME_PHASE_SET_FLAG] = multiframe_phase_set_flag_reg;
    status[sltr_pkg::ST_PLL] = i_pll_locked;
  end

  always_comb
  begin
    test_next = test_reg;
    did_next = did_reg;
    comma_sel_next = comma_sel_reg;
    en_next = en_reg;
    rdata_next = 32'h00000000;
    err_next = 1'b0;
    if (wr)
    begin
      unique case (i_paddr)
        sltr_pkg::ADDR_TEST: test_next = i_pwdata[4:0];
        sltr_pkg::ADDR_IDENT: did_next = {i_pwdata[7:1], 1'b0};
        sltr_pkg::ADDR_COMMA: comma_sel_next = i_pwdata[1:0];
        sltr_pkg::ADDR_CTRL: en_next = i_pwdata[0];
        sltr_pkg::ADDR_STATUS: ;
        default: err_next = 1'b1;
      endcase
    end
    else if (acc)
    begin
      unique case (i_paddr)
        sltr_pkg::ADDR_TEST: rdata_next = {27'h0, test_reg};
        sltr_pkg::ADDR_IDENT: rdata_next = {24'h0, did_reg};
        sltr_pkg::ADDR_COMMA: rdata_next = {30'h0, comma_sel_reg};
        sltr_pkg::ADDR_CTRL: rdata_next = {31'h0, en_reg};
        sltr_pkg::ADDR_STATUS: rdata_next = {24'h0, status};
        default: err_next = 1'b1;
      endcase
    end
  end

  // sticky flags: a new event wins over a write-one clear
  always_comb
  begin
    realigned_next = realigned_reg;
    multiframe_phase_set_flag_next = multiframe_phase_set_flag_reg;
    armed_next = armed_reg;
    if (!en_reg)
      armed_next = 1'b1;
    if (wr && i_paddr == sltr_pkg::ADDR_STATUS)
    begin
      if (i_pwdata[sltr_pkg::ST_REALIGNED])
        realigned_next = 1'b0;
      if (i_pwdata[sltr_pkg::ST_MULTIFRAME_PHASE_SET_FLAG])
        multiframe_phase_set_flag_next = 1'b0;
    end
    if (i_sysref_event && i_phase_shifted)
      realigned_next = 1'b1;
    if (i_sysref_event && en_reg && armed_reg)
    begin
      multiframe_phase_set_flag_next = 1'b1;
      armed_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  sltr_pattern_gen u_gen (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_enable(en_reg),
    .i_select(test_reg),
    .i_is_8b10b(i_is_8b10b),
    .i_data(i_sample_data),
    .o_word(gen_word),
    .o_is_k(gen_k)
  );

  // identifier and comma overlays apply to normal data only
  always_comb
  begin
    a_next = gen_word;
    b_next = gen_word;
    ak_next = gen_k;
    bk_next = gen_k;
    if (test_reg == sltr_pkg::TP_NORMAL && i_ila_did_slot)
    begin
      a_next = {8'h00, did_reg};
      b_next = {8'h00, did_reg + 8'h01};
    end
    else if (test_reg == sltr_pkg::TP_NORMAL && i_eof_slot && i_is_8b10b)
    begin
      a_next = {gen_word[15:8], eof_char(comma_sel_reg)};
      b_next = {gen_word[15:8], eof_char(comma_sel_reg)};
      ak_next = 1'b1;
      bk_next = 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      test_reg <= sltr_pkg::TEST_RST;
      did_reg <= sltr_pkg::IDENT_RST;
      comma_sel_reg <= sltr_pkg::COMMA_RST;
      en_reg <= 1'b0;
      realigned_reg <= 1'b0;
      multiframe_phase_set_flag_reg <= 1'b0;
      armed_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      a_reg <= 16'h0000;
      b_reg <= 16'h0000;
      ak_reg <= 1'b0;
      bk_reg <= 1'b0;
    end
    else
    begin
      test_reg <= test_next;
      did_reg <= did_next;
      comma_sel_reg <= comma_sel_next;
      en_reg <= en_next;
      realigned_reg <= realigned_next;
      multiframe_phase_set_flag_reg <= multiframe_phase_set_flag_next;
      armed_reg <= armed_next;
      rdata_reg <= rdata_next;
      a_reg <= a_next;
      b_reg <= b_next;
      ak_reg <= ak_next;
      bk_reg <= bk_next;
    end
  end

  // read data is combinational in the access cycle; otherwise rdata_reg, which holds the read word for one cycle and then zero
  assign o_prdata = (acc && !i_pwrite) ? rdata_next : rdata_reg;
  assign o_pslverr = acc && err_next;
  assign o_serial_link_enable = en_reg;
  assign o_link_a_word = a_reg;
  assign o_link_a_is_k = ak_reg;
  assign o_link_b_word = b_reg;
  assign o_link_b_is_k = bk_reg;

  ////////////////////////////////////////////////////////////////
  property p_did_even;
    @(posedge i_mclk) disable iff (i_reset) !did_reg[0];
  endproperty
  a_did_even: assert property (p_did_even) else $error("did bit 0 set");

  property p_link_b_plus_one;
    @(posedge i_mclk) disable iff (i_reset)
      (test_reg == sltr_pkg::TP_NORMAL && i_ila_did_slot)
      |=> (o_link_b_word[7:0] == $past(did_reg) + 8'h01 && o_link_a_word[7:0] == $past(did_reg));
  endproperty
  a_link_b_plus_one: assert property (p_link_b_plus_one) else $error("link id mismatch");

  property p_realign_set;
    @(posedge i_mclk) disable iff (i_reset) (i_sysref_event && i_phase_shifted) |=> realigned_reg;
  endproperty
  a_realign_set: assert property (p_realign_set) else $error("realigned not set");

  property p_multiframe_phase_set_flag_clear;
    @(posedge i_mclk) disable iff (i_reset)
      (wr && i_paddr == sltr_pkg::ADDR_STATUS && i_pwdata[sltr_pkg::ST_MULTIFRAME_PHASE_SET_FLAG] && !i_sysref_event)
      |=> !multiframe_phase_set_flag_reg;
  endproperty
  a_multiframe_phase_set_flag_clear: assert property (p_multiframe_phase_set_flag_clear) else $error("multiframe_phase_set_flag not cleared");

  property p_sync_status;
    @(posedge i_mclk) disable iff (i_reset)
      (acc && !i_pwrite && i_paddr == sltr_pkg::ADDR_STATUS)
      |-> o_prdata[sltr_pkg::ST_SYNC] == i_sync_req_n;
  endproperty
  a_sync_status: assert property (p_sync_status) else $error("sync status wrong");

  property p_hold_low;
    @(posedge i_mclk) disable iff (i_reset)
      (en_reg && test_reg == sltr_pkg::TP_LOW) [*2] |=> o_link_a_word == 16'h0000;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("not held low");

  property p_hold_high;
    @(posedge i_mclk) disable iff (i_reset)
      (en_reg && test_reg == sltr_pkg::TP_HIGH) [*2] |=> o_link_a_word == 16'hffff;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("not held high");

  property p_clock_pat;
    @(posedge i_mclk) disable iff (i_reset)
      (en_reg && test_reg == sltr_pkg::TP_CLOCK) [*2] |=> o_link_a_word == sltr_pkg::CLOCK_WORD;
  endproperty
  a_clock_pat: assert property (p_clock_pat) else $error("clock pattern wrong");

  property p_kchar_only_8b10b;
    @(posedge i_mclk) disable iff (i_reset)
      (!$past(i_is_8b10b) && !$past(i_is_8b10b, 2)) |-> !o_link_a_is_k;
  endproperty
  a_kchar_only_8b10b: assert property (p_kchar_only_8b10b) else $error("k char outside 8b10b");

  c_multiframe_phase_set_flag: cover property (@(posedge i_mclk) disable iff (i_reset) !multiframe_phase_set_flag_reg ##1 multiframe_phase_set_flag_reg);
  c_prbs: cover property (@(posedge i_mclk) disable iff (i_reset) en_reg && test_reg == sltr_pkg::TP_PRBS7);
  c_eof: cover property (@(posedge i_mclk) disable iff (i_reset) o_link_a_is_k && comma_sel_reg == 2'h1);
endmodule : sltr_regs
`default_nettype wire

// >>> dv/sltr_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module sltr_rx_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // link side
  input wire logic [15:0] i_word,
  input wire logic i_is_k,
  input wire logic i_resync,
  output logic o_sync_req_n
);
  // request held until four commas in a row; any other word restarts the count
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic req_n_reg;
  logic req_n_next;
  always_comb
  begin
    count_next = count_reg;
    req_n_next = req_n_reg;
    if (i_reset || i_resync)
    begin
      count_next = 3'h0;
      req_n_next = 1'b0;
    end
    else if (!req_n_reg)
    begin
      count_next = (i_is_k && i_word[7:0] == sltr_pkg::K28_5) ? count_reg + 3'h1 : 3'h0;
      req_n_next = (count_next == 3'h4);
    end
  end
  always_ff @(posedge i_mclk)
  begin
    count_reg <= count_next;
    req_n_reg <= req_n_next;
  end
  assign o_sync_req_n = req_n_reg;
endmodule : sltr_rx_model
`default_nettype wire

// >>> dv/serial_link_test_and_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_test_and_status_regs_bench;
  localparam logic [15:0] SD = 16'ha5c3;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic link_up = 1'b0, pll = 1'b0, sysref = 1'b0, shift = 1'b0, is8b = 1'b1;
  logic eof = 1'b0, ila = 1'b0, resync = 1'b0, ka, kb, en, sync_n, er, k0;
  logic [15:0] wa, wb, w0, w1;
  int checks = 0, mismatches = 0, cyc = 0;
  always #20 mclk = ~mclk;
  sltr_regs i_dut (.i_mclk(mclk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_link_up(link_up), .i_sync_req_n(sync_n),
    .i_sysref_event(sysref), .i_phase_shifted(shift), .i_pll_locked(pll),
    .i_is_8b10b(is8b), .i_eof_slot(eof), .i_ila_did_slot(ila), .i_sample_data(SD),
    .o_serial_link_enable(en), .o_link_a_word(wa), .o_link_a_is_k(ka),
    .o_link_b_word(wb), .o_link_b_is_k(kb));
  sltr_rx_model i_rx (.i_mclk(mclk), .i_reset(rst), .i_word(wa), .i_is_k(ka),
    .i_resync(resync), .o_sync_req_n(sync_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // called right after a rising edge; returns one edge after the access ends
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rchk(input logic [13:0] a, input logic [31:0] e, input logic ee = 1'b0);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", 32'(ee), 32'(er));
  endtask : rchk
  task automatic set_mode(input logic [4:0] c);
    apb(1'b1, sltr_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, sltr_pkg::ADDR_TEST, {27'h0, c});
    apb(1'b1, sltr_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
  endtask : set_mode
  // 0 identifier slot, 1 comma slot, 2 sysref
  task automatic pulse(input int which);
    ila <= (which == 0);
    eof <= (which == 1);
    sysref <= (which == 2);
    @(posedge mclk);
    ila <= 1'b0;
    eof <= 1'b0;
    sysref <= 1'b0;
    #1;
    w0 = wa;
    w1 = wb;
    k0 = ka;
    @(posedge mclk);
  endtask : pulse
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    static logic [4:0] fc [7] = '{5'h0a, 5'h0b, 5'h0f, 5'h00, 5'h0c, 5'h11, 5'h1f};
    static logic [15:0] fe [7] = '{16'h0000, 16'hffff, sltr_pkg::CLOCK_WORD, SD, SD, SD, SD};
    static logic [4:0] kc [3] = '{5'h06, 5'h07, 5'h10};
    static logic [7:0] ke [3] = '{sltr_pkg::D21_5, sltr_pkg::K28_5, sltr_pkg::K28_7};
    static logic [4:0] mc [6] = '{5'h01, 5'h02, 5'h03, 5'h0d, 5'h0e, 5'h04};
    static logic [4:0] oc [4] = '{5'h07, 5'h08, 5'h09, 5'h10};
    static logic [7:0] ce [4] = '{sltr_pkg::K28_7, sltr_pkg::K28_1, sltr_pkg::K28_5, sltr_pkg::K28_7};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rchk(sltr_pkg::ADDR_TEST, 32'h0);
    rchk(sltr_pkg::ADDR_IDENT, 32'h0);
    rchk(sltr_pkg::ADDR_COMMA, 32'h0);
    rchk(sltr_pkg::ADDR_STATUS, 32'h0);
    rchk(14'h0ffc, 32'h0, 1'b1);
    apb(1'b1, sltr_pkg::ADDR_TEST, 32'hffffffff);
    rchk(sltr_pkg::ADDR_TEST, 32'h1f);
    apb(1'b1, sltr_pkg::ADDR_IDENT, 32'h35);
    rchk(sltr_pkg::ADDR_IDENT, 32'h34);
    set_mode(5'h00);
    pulse(0);
    chk("link a identifier", 32'h34, {24'h0, w0[7:0]});
    chk("link b identifier", 32'h35, {24'h0, w1[7:0]});
    chk("link enable", 32'h1, {31'h0, en});
    foreach (fc[i])
    begin
      set_mode(fc[i]);
      chk("link a word", {16'h0, fe[i]}, {16'h0, wa});
      chk("link b word", {16'h0, fe[i]}, {16'h0, wb});
    end
    foreach (kc[i])
    begin
      set_mode(kc[i]);
      chk("character", {24'h0, ke[i]}, {24'h0, wa[7:0]});
      chk("link b k", {31'h0, kc[i] != 5'h06}, {31'h0, kb});
    end
    foreach (mc[i])
    begin
      set_mode(mc[i]);
      w0 = wa;
      @(posedge mclk);
      chk("word moves", 32'h1, 32'(wa != w0));
    end
    foreach (oc[i])
    begin
      set_mode(oc[i]);
      chk("word not data", 32'h1, 32'(wa != SD));
    end
    set_mode(5'h05);
    chk("transport word", 32'h1, 32'(wa != SD));
    is8b <= 1'b0;
    foreach (oc[i])
    begin
      set_mode(oc[i]);
      chk("k mode off", {16'h0, SD}, {16'h0, wa});
    end
    is8b <= 1'b1;
    set_mode(5'h07);
    repeat (10) @(posedge mclk);
    link_up <= 1'b1;
    pll <= 1'b1;
    @(posedge mclk);
    rchk(sltr_pkg::ADDR_STATUS, 32'h64);
    set_mode(5'h00);
    resync <= 1'b1;
    @(posedge mclk);
    resync <= 1'b0;
    repeat (2) @(posedge mclk);
    rchk(sltr_pkg::ADDR_STATUS, 32'h44);
    foreach (ce[i])
    begin
      apb(1'b1, sltr_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, sltr_pkg::ADDR_COMMA, i);
      apb(1'b1, sltr_pkg::ADDR_CTRL, 32'h1);
      pulse(1);
      chk("comma", {23'h0, 1'b1, ce[i]}, {23'h0, k0, w0[7:0]});
    end
    is8b <= 1'b0;
    pulse(1);
    chk("no comma", {16'h0, SD}, {16'h0, w0});
    is8b <= 1'b1;
    set_mode(5'h00);
    shift <= 1'b1;
    pulse(2);
    rchk(sltr_pkg::ADDR_STATUS, 32'h5c);
    apb(1'b1, sltr_pkg::ADDR_STATUS, 32'h18);
    rchk(sltr_pkg::ADDR_STATUS, 32'h44);
    shift <= 1'b0;
    pulse(2);
    rchk(sltr_pkg::ADDR_STATUS, 32'h44);
    shift <= 1'b1;
    pulse(2);
    rchk(sltr_pkg::ADDR_STATUS, 32'h54);
    wrap_up();
  end
endmodule : serial_link_test_and_status_regs_bench
`default_nettype wire
